//--- shared/nv_host_pkg.sv
// package: constants for the nonvolatile sram host controller
package nv_host_pkg;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned ADDR_W   = 13;
  localparam int unsigned DATA_W   = 8;
  // times as printed
  localparam int unsigned STORE_DURATION_MS         = 10;
  localparam int unsigned CYCLE_FINISH_ALLOWANCE_US = 1;
  localparam int unsigned INHIBIT_RELEASE_DELAY_NS  = 700;
  localparam int unsigned STORE_REQUEST_PULSE_NS    = 15;
  localparam int unsigned STORE_BUSY_DELAY_NS       = 300;
  localparam int unsigned ACCESS_NS                 = 100;
  // derived cycle counts
  localparam int unsigned STORE_DURATION_CYC =
    STORE_DURATION_MS * (CLOCK_HZ / 1000);
  localparam int unsigned CYCLE_FINISH_CYC =
    (CYCLE_FINISH_ALLOWANCE_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned INHIBIT_RELEASE_CYC =
    (INHIBIT_RELEASE_DELAY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STORE_REQUEST_CYC =
    ((STORE_REQUEST_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000 < 1) ? 1 :
    (STORE_REQUEST_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned STORE_BUSY_CYC =
    STORE_BUSY_DELAY_NS * (CLOCK_HZ / 1_000_000) / 1000;
  localparam int unsigned ACCESS_CYC =
    (ACCESS_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  // software sequence addresses
  localparam logic [12:0] SEQ_ADDR0   = 13'h0000;
  localparam logic [12:0] SEQ_ADDR1   = 13'h1555;
  localparam logic [12:0] SEQ_ADDR2   = 13'h0AAA;
  localparam logic [12:0] SEQ_ADDR3   = 13'h1FFF;
  localparam logic [12:0] SEQ_ADDR4   = 13'h10F0;
  localparam logic [12:0] SEQ_STORE   = 13'h0F0F;
  localparam logic [12:0] SEQ_RECALL  = 13'h0F0E;
  // command codes
  typedef enum logic [2:0] {
    CMD_READ   = 3'b000,
    CMD_WRITE  = 3'b001,
    CMD_HWSTORE = 3'b010,
    CMD_SWSTORE = 3'b011,
    CMD_RECALL = 3'b100
  } cmd_t;
endpackage : nv_host_pkg

//--- shared/pin_seq_if.sv
// interface: sequencer control between host top and pin sequencer
`timescale 1ns/100ps
`default_nettype none
interface pin_seq_if;
  logic        start;
  logic        is_write;
  logic        oe_read;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctrl (output start, is_write, oe_read, addr, wdata, input done, rdata);
  modport seq  (input start, is_write, oe_read, addr, wdata, output done, rdata);
endinterface : pin_seq_if
`default_nettype wire

//--- hw/nv_pin_cycle.sv
// module: one chip-select-controlled sram cycle on the device pins
`timescale 1ns/100ps
`default_nettype none
module nv_pin_cycle
  import nv_host_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // sampled data bus
  input  wire logic [7:0]  i_data_sync,
  // control
  pin_seq_if.seq           ctl,
  // pins
  output logic             o_chip_sel_n,
  output logic             o_write_n,
  output logic             o_out_gate_n,
  output logic [12:0]      o_byte_address,
  output logic [7:0]       o_data_out,
  output logic             o_data_oe
);
  typedef enum logic [1:0] {
    PC_IDLE = 2'b00,
    PC_ACT  = 2'b01,
    PC_END  = 2'b10
  } pc_state_t;

  pc_state_t   state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        cs_r, cs_nxt, we_r, we_nxt, og_r, og_nxt, oe_r, oe_nxt;
  logic [12:0] a_r, a_nxt;
  logic [7:0]  d_r, d_nxt, rd_r, rd_nxt;
  logic        done_r, done_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cs_nxt    = cs_r;
    we_nxt    = we_r;
    og_nxt    = og_r;
    oe_nxt    = oe_r;
    a_nxt     = a_r;
    d_nxt     = d_r;
    rd_nxt    = rd_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      PC_IDLE: begin
        if (ctl.start) begin
          state_nxt = PC_ACT;
          a_nxt     = ctl.addr;
          d_nxt     = ctl.wdata;
          cs_nxt    = 1'b0;
          we_nxt    = ~ctl.is_write;
          og_nxt    = ~(ctl.oe_read & ~ctl.is_write);
          oe_nxt    = ctl.is_write;
          // two extra cycles so the data synchroniser holds pin data at capture
          cnt_nxt   = 4'(ACCESS_CYC + 2);
        end
      end
      PC_ACT: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = PC_END;
          rd_nxt    = i_data_sync;
          cs_nxt    = 1'b1;
          we_nxt    = 1'b1;
          og_nxt    = 1'b1;
        end
      end
      PC_END: begin
        oe_nxt    = 1'b0;
        done_nxt  = 1'b1;
        state_nxt = PC_IDLE;
      end
      default: state_nxt = PC_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= PC_IDLE;
      cnt_r   <= 4'h0;
      cs_r    <= 1'b1;
      we_r    <= 1'b1;
      og_r    <= 1'b1;
      oe_r    <= 1'b0;
      a_r     <= 13'h0000;
      d_r     <= 8'h00;
      rd_r    <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cs_r    <= cs_nxt;
      we_r    <= we_nxt;
      og_r    <= og_nxt;
      oe_r    <= oe_nxt;
      a_r     <= a_nxt;
      d_r     <= d_nxt;
      rd_r    <= rd_nxt;
      done_r  <= done_nxt;
    end
  end

  assign o_chip_sel_n   = cs_r;
  assign o_write_n      = we_r;
  assign o_out_gate_n   = og_r;
  assign o_byte_address = a_r;
  assign o_data_out     = d_r;
  assign o_data_oe      = oe_r;
  assign ctl.done       = done_r;
  assign ctl.rdata      = rd_r;

  // read cycles keep write strobe high
  read_strobe_high_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == PC_ACT && og_r == 1'b0) |-> we_r)
    else $error("write strobe low during read");
  // address stable while selected
  addr_stable_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (!cs_r && $past(!cs_r)) |-> $stable(a_r))
    else $error("address moved while selected");
endmodule : nv_pin_cycle
`default_nettype wire

//--- hw/nv_sram_host.sv
// module: host-side controller for a byte-wide nonvolatile static ram
// ----------------------------------------------------------------------
// Overview of operation
// - every read cycle is issued with write strobe and store/busy held high.
// - six reads at fixed addresses start a software store or recall.
// - the write strobe stays high through all six reads of the sequence.
// - the store request pulse on store/busy lasts at least 15 ns.
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module nv_sram_host
  import nv_host_pkg::*;
#(
  parameter int unsigned STORE_WAIT_CYC = STORE_DURATION_CYC
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // user command port
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_op,
  input  wire logic [12:0] i_cmd_addr,
  input  wire logic [7:0]  i_cmd_wdata,
  input  wire logic        i_cmd_oe_read,
  output logic             o_cmd_ready,
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_rdata,
  output logic             o_rsp_error,
  // device pins
  output logic             o_chip_sel_n,
  output logic             o_write_n,
  output logic             o_out_gate_n,
  output logic [12:0]      o_byte_address,
  input  wire logic [7:0]  i_data_io,
  output logic [7:0]       o_data_io,
  output logic             o_data_io_oe,
  input  wire logic        i_hw_store_busy_n,
  output logic             o_hw_store_busy_n,
  output logic             o_hw_store_busy_oe
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_ACCESS  = 4'b0001,
    ST_SEQ     = 4'b0010,
    ST_HB_PULL = 4'b0011,
    ST_HB_REL  = 4'b0100,
    ST_HB_WAIT = 4'b0101,
    ST_RECOVER = 4'b0110,
    ST_NV_WAIT = 4'b0111,
    ST_RESP    = 4'b1000
  } state_t;

  localparam int unsigned CNT_W =
    $clog2(STORE_WAIT_CYC + CYCLE_FINISH_CYC + STORE_BUSY_CYC + 1);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] data_s1_r, data_s2_r;
  logic       hsb_s1_r, hsb_s2_r;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
      hsb_s1_r  <= 1'b1;
      hsb_s2_r  <= 1'b1;
    end else begin
      data_s1_r <= i_data_io;
      data_s2_r <= data_s1_r;
      hsb_s1_r  <= i_hw_store_busy_n;
      hsb_s2_r  <= hsb_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // sequence address lookup
  // ----------------------------------------------------------------------
  function automatic logic [12:0] seq_addr(input logic [2:0] idx, input logic recall);
    logic [12:0] a;
    a = SEQ_ADDR0;
    unique case (idx)
      3'h0: a = SEQ_ADDR0;
      3'h1: a = SEQ_ADDR1;
      3'h2: a = SEQ_ADDR2;
      3'h3: a = SEQ_ADDR3;
      3'h4: a = SEQ_ADDR4;
      default: a = recall ? SEQ_RECALL : SEQ_STORE;
    endcase
    return a;
  endfunction : seq_addr

  pin_seq_if cyc ();

  nv_pin_cycle u_cycle (
    .i_clock        (i_clock),
    .i_srst         (i_srst),
    .i_data_sync    (data_s2_r),
    .ctl            (cyc),
    .o_chip_sel_n   (o_chip_sel_n),
    .o_write_n      (o_write_n),
    .o_out_gate_n   (o_out_gate_n),
    .o_byte_address (o_byte_address),
    .o_data_out     (o_data_io),
    .o_data_oe      (o_data_io_oe)
  );

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  state_t            state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [2:0]        idx_r, idx_nxt;
  logic              recall_r, recall_nxt;
  logic              oe_rd_r, oe_rd_nxt;
  logic [7:0]        rdata_r, rdata_nxt;
  logic              rvalid_r, rvalid_nxt, err_r, err_nxt;
  logic              ready_r, ready_nxt;
  logic              hsb_oe_r, hsb_oe_nxt;
  logic              start_r, start_nxt, wr_r, wr_nxt;
  logic [12:0]       addr_r, addr_nxt;
  logic [7:0]        wdat_r, wdat_nxt;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    idx_nxt    = idx_r;
    recall_nxt = recall_r;
    oe_rd_nxt  = oe_rd_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt    = 1'b0;
    ready_nxt  = 1'b0;
    hsb_oe_nxt = hsb_oe_r;
    start_nxt  = 1'b0;
    wr_nxt     = wr_r;
    addr_nxt   = addr_r;
    wdat_nxt   = wdat_r;
    unique case (state_r)
      ST_IDLE: begin
        ready_nxt = 1'b1;
        if (i_cmd_valid && ready_r) begin
          ready_nxt = 1'b0;
          oe_rd_nxt = i_cmd_oe_read;
          addr_nxt  = i_cmd_addr;
          wdat_nxt  = i_cmd_wdata;
          idx_nxt   = 3'h0;
          unique case (i_cmd_op)
            CMD_READ, CMD_WRITE: begin
              state_nxt = ST_ACCESS;
              wr_nxt    = (i_cmd_op == CMD_WRITE);
              start_nxt = 1'b1;
            end
            CMD_HWSTORE: begin
              state_nxt  = ST_HB_PULL;
              hsb_oe_nxt = 1'b1;
              cnt_nxt    = CNT_W'(STORE_REQUEST_CYC);
            end
            CMD_SWSTORE, CMD_RECALL: begin
              state_nxt  = ST_SEQ;
              recall_nxt = (i_cmd_op == CMD_RECALL);
              wr_nxt     = 1'b0;
              addr_nxt   = seq_addr(3'h0, 1'b0);
              start_nxt  = 1'b1;
            end
            default: begin
              state_nxt = ST_RESP;
              err_nxt   = 1'b1;
            end
          endcase
        end
      end
      ST_ACCESS: begin
        if (cyc.done) begin
          rdata_nxt = cyc.rdata;
          state_nxt = ST_RESP;
        end
      end
      ST_SEQ: begin
        if (cyc.done) begin
          rdata_nxt = cyc.rdata;
          if (idx_r == 3'h5) begin
            state_nxt = ST_NV_WAIT;
            cnt_nxt   = CNT_W'(STORE_WAIT_CYC);
          end else begin
            idx_nxt   = idx_r + 3'h1;
            addr_nxt  = seq_addr(idx_r + 3'h1, recall_r);
            start_nxt = 1'b1;
          end
        end
      end
      ST_HB_PULL: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_r == CNT_W'(1)) begin
          hsb_oe_nxt = 1'b0;
          state_nxt  = ST_HB_WAIT;
          cnt_nxt    = CNT_W'(STORE_WAIT_CYC + CYCLE_FINISH_CYC + STORE_BUSY_CYC);
        end
      end
      ST_HB_WAIT: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (hsb_s2_r && cnt_r < CNT_W'(STORE_WAIT_CYC + CYCLE_FINISH_CYC)) begin
          state_nxt = ST_RECOVER;
          cnt_nxt   = CNT_W'(INHIBIT_RELEASE_CYC);
        end else if (cnt_r == CNT_W'(0)) begin
          err_nxt   = 1'b1;
          state_nxt = ST_RESP;
        end
      end
      ST_RECOVER, ST_NV_WAIT: begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_r == CNT_W'(0)) begin
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        rvalid_nxt = 1'b1;
        err_nxt    = err_r;
        state_nxt  = ST_HB_REL;
      end
      ST_HB_REL: begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      idx_r    <= 3'h0;
      recall_r <= 1'b0;
      oe_rd_r  <= 1'b1;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
      ready_r  <= 1'b0;
      hsb_oe_r <= 1'b0;
      start_r  <= 1'b0;
      wr_r     <= 1'b0;
      addr_r   <= 13'h0000;
      wdat_r   <= 8'h00;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      idx_r    <= idx_nxt;
      recall_r <= recall_nxt;
      oe_rd_r  <= oe_rd_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
      ready_r  <= ready_nxt;
      hsb_oe_r <= hsb_oe_nxt;
      start_r  <= start_nxt;
      wr_r     <= wr_nxt;
      addr_r   <= addr_nxt;
      wdat_r   <= wdat_nxt;
    end
  end

  assign cyc.start    = start_r;
  assign cyc.is_write = wr_r;
  assign cyc.oe_read  = oe_rd_r;
  assign cyc.addr     = addr_r;
  assign cyc.wdata    = wdat_r;

  assign o_cmd_ready        = ready_r;
  assign o_rsp_valid        = rvalid_r;
  assign o_rsp_rdata        = rdata_r;
  assign o_rsp_error        = err_r;
  assign o_hw_store_busy_n  = 1'b0;
  assign o_hw_store_busy_oe = hsb_oe_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  no_access_store_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hsb_oe_r |-> o_chip_sel_n)
    else $error("chip selected while store requested");
  pulse_width_a: assert property (@(posedge i_clock) disable iff (i_srst)
    $fell(hsb_oe_r) |-> $past(hsb_oe_r, STORE_REQUEST_CYC))
    else $error("store request pulse too short");
  seq_no_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == ST_SEQ) |-> o_write_n)
    else $error("write strobe low in sequence");
  seq_count_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == ST_SEQ && cyc.done && idx_r == 3'h5) |=> state_r == ST_NV_WAIT)
    else $error("sequence did not end after six reads");
  resp_after_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == ST_RESP) |=> (o_rsp_valid && state_r == ST_HB_REL))
    else $error("response not given");
endmodule : nv_sram_host
`default_nettype wire

//--- tb/nv_sram_model.sv
// model: behavioural byte-wide nonvolatile sram as seen on its pins
`timescale 1ns/100ps
`default_nettype none
module nv_sram_model
  import nv_host_pkg::*;
#(
  parameter int STORE_CYC   = 15,
  parameter int RECOVER_CYC = 6
) (
  // sampling clock
  input  wire logic        i_clock,
  // pins from the host
  input  wire logic        i_chip_sel_n,
  input  wire logic        i_write_n,
  input  wire logic        i_out_gate_n,
  input  wire logic [12:0] i_byte_address,
  input  wire logic [7:0]  i_data_io,
  input  wire logic        i_hw_store_busy_n,
  // pins to the host
  output logic [7:0]       o_data_io,
  output logic             o_data_oe,
  output logic             o_busy_oe
);
  logic [7:0]  sram_r [8192];
  logic [7:0]  nv_r [8192];
  logic [12:0] seq_tab [5] = '{SEQ_ADDR0, SEQ_ADDR1, SEQ_ADDR2, SEQ_ADDR3, SEQ_ADDR4};
  int          seq_r    = 0;
  int          st_r     = 0;
  int          cnt_r    = 0;
  int          stores   = 0;
  int          recalls  = 0;
  int          faults   = 0;
  logic        dirty_r  = 1'b0;
  logic        cs_q     = 1'b1;
  logic        we_low_r = 1'b0;
  logic [12:0] addr_q   = 13'h0000;
  logic        sixth;
  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // states: 0 idle, 1 hw store, 2 wait release, 3 recover, 4 sw operation
  assign sixth = (seq_r == 5) && (i_byte_address == SEQ_STORE || i_byte_address == SEQ_RECALL);
  assign o_busy_oe = (st_r == 1);
  always_comb begin
    o_data_io = sram_r[i_byte_address];
    o_data_oe = !i_chip_sel_n && !i_out_gate_n && i_write_n && i_hw_store_busy_n
                && (st_r == 0) && !sixth;
  end
  // ----------------------------------------------------------------
  // array access, sequence and store
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    cs_q <= i_chip_sel_n;
    if (!i_chip_sel_n && (st_r != 0 || !i_hw_store_busy_n)) faults <= faults + 1;
    if (!i_chip_sel_n) begin
      addr_q <= i_byte_address;
      if (!i_write_n) we_low_r <= 1'b1;
    end
    if (st_r == 0 && !i_chip_sel_n && !i_write_n && i_hw_store_busy_n) begin
      sram_r[i_byte_address] <= i_data_io;
      dirty_r <= 1'b1;
    end
    if (!cs_q && i_chip_sel_n && st_r == 0) begin
      we_low_r <= 1'b0;
      if (we_low_r) seq_r <= 0;
      else if (seq_r == 5 && (addr_q == SEQ_STORE || addr_q == SEQ_RECALL)) begin
        if (addr_q == SEQ_STORE) begin
          nv_r <= sram_r;
          stores <= stores + 1;
        end else begin
          sram_r <= nv_r;
          recalls <= recalls + 1;
        end
        dirty_r <= 1'b0;
        seq_r <= 0;
        st_r <= 4;
        cnt_r <= STORE_CYC;
      end else if (seq_r < 5 && addr_q == seq_tab[seq_r]) seq_r <= seq_r + 1;
      else seq_r <= (addr_q == SEQ_ADDR0) ? 1 : 0;
    end
    case (st_r)
      // a one-cycle host pulse is long enough to be seen
      0: if (!i_hw_store_busy_n) begin
        st_r <= dirty_r ? 1 : 2;
        cnt_r <= STORE_CYC;
      end
      1: if (cnt_r == 1) begin
        nv_r <= sram_r;
        stores <= stores + 1;
        dirty_r <= 1'b0;
        st_r <= 2;
      end else cnt_r <= cnt_r - 1;
      2: if (i_hw_store_busy_n) begin
        st_r <= 3;
        cnt_r <= RECOVER_CYC;
      end
      3, 4: if (cnt_r == 1) st_r <= 0;
        else cnt_r <= cnt_r - 1;
      default: st_r <= 0;
    endcase
  end
endmodule : nv_sram_model
`default_nettype wire

//--- tb/testbench.sv
// bench: nonvolatile sram host controller against a pin-level device model
`timescale 1ns/100ps
`default_nettype none
module testbench
  import nv_host_pkg::*;
;
  localparam int unsigned WAIT_CYC = 40;
  typedef struct packed {logic chk; logic err; logic [7:0] data;} exp_t;
  logic        i_clock = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic [2:0]  i_cmd_op = 3'h0;
  logic [12:0] i_cmd_addr = 13'h0000;
  logic [7:0]  i_cmd_wdata = 8'h00;
  logic        i_cmd_oe_read = 1'b1;
  logic        o_cmd_ready, o_rsp_valid, o_rsp_error, chip_sel_n, write_n, out_gate_n;
  logic [7:0]  o_rsp_rdata, host_data, dev_data, data_wire;
  logic [7:0]  last_r = 8'h00;
  logic [12:0] byte_address;
  logic        host_oe, dev_oe, busy_n, busy_oe, dev_busy_oe, hsb_wire;
  logic [7:0]  mem [8192];
  exp_t        exp_q [$];
  int          err_count = 0;
  int          checks = 0;
  int          seed = 34537;
  // ----------------------------------------------------------------
  // clock, wires and instances
  // ----------------------------------------------------------------
  always #50 i_clock = ~i_clock;
  // undriven data bus shows a changing pattern; store/busy has a pull-up
  assign data_wire = host_oe ? host_data : (dev_oe ? dev_data : ~last_r);
  assign hsb_wire  = busy_oe ? busy_n : !dev_busy_oe;
  always @(posedge i_clock) last_r <= data_wire;
  nv_sram_host #(.STORE_WAIT_CYC(WAIT_CYC)) i_nv_sram_host (
    .i_clock(i_clock), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata), .i_cmd_oe_read(i_cmd_oe_read),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
    .o_rsp_error(o_rsp_error), .o_chip_sel_n(chip_sel_n), .o_write_n(write_n),
    .o_out_gate_n(out_gate_n), .o_byte_address(byte_address), .i_data_io(data_wire),
    .o_data_io(host_data), .o_data_io_oe(host_oe), .i_hw_store_busy_n(hsb_wire),
    .o_hw_store_busy_n(busy_n), .o_hw_store_busy_oe(busy_oe));
  nv_sram_model #(.STORE_CYC(15), .RECOVER_CYC(6)) i_nv_sram_model (
    .i_clock(i_clock), .i_chip_sel_n(chip_sel_n), .i_write_n(write_n),
    .i_out_gate_n(out_gate_n), .i_byte_address(byte_address), .i_data_io(data_wire),
    .i_hw_store_busy_n(hsb_wire), .o_data_io(dev_data), .o_data_oe(dev_oe),
    .o_busy_oe(dev_busy_oe));
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : cmp8
  task automatic cmp1(input string what, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, s);
    end
  endtask : cmp1
  task automatic cmpn(input string what, input int e, input int s);
    checks++;
    if (s != e) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", what, e, s);
    end
  endtask : cmpn
  task automatic tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic give_up(input string what);
    err_count++;
    $display("BAD %s expected done seen timeout", what);
    tally_and_finish();
  endtask : give_up
  // ----------------------------------------------------------------
  // command driver and response watcher
  // ----------------------------------------------------------------
  task automatic send(input logic [2:0] op, input logic [12:0] a, input logic [7:0] d,
                      input logic oe, input exp_t e);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'b1) begin
      @(negedge i_clock);
      if (++n > 2000) give_up("cmd_ready");
    end
    exp_q.push_back(e);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= op;
    i_cmd_addr <= a;
    i_cmd_wdata <= d;
    i_cmd_oe_read <= oe;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    i_cmd_wdata <= 8'($random(seed));
    n = 0;
    while (exp_q.size() != 0) begin
      @(negedge i_clock);
      if (++n > 2000) give_up("rsp_valid");
    end
  endtask : send
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    mem[a] = d;
    send(CMD_WRITE, a, d, 1'b1, {1'b0, 1'b0, 8'h00});
  endtask : wr
  task automatic rd(input logic [12:0] a);
    send(CMD_READ, a, 8'h00, 1'b1, {1'b1, 1'b0, mem[a]});
  endtask : rd
  always @(negedge i_clock) begin : watch
    exp_t e;
    if (o_rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) give_up("rsp_valid unexpected");
      e = exp_q.pop_front();
      cmp1("rsp_error", e.err, o_rsp_error);
      if (e.chk) cmp8("rsp_rdata", e.data, o_rsp_rdata);
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin : main
    int i;
    int s0;
    logic [12:0] a;
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    @(negedge i_clock);
    for (i = 0; i < 10; i++) begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
      wr(a, 8'($random(seed)));
      rd(a);
    end
    send(CMD_READ, a, 8'h00, 1'b0, {1'b0, 1'b0, 8'h00});
    wr(13'h0123, 8'h5A);
    s0 = i_nv_sram_model.stores;
    send(CMD_HWSTORE, 13'h0000, 8'h00, 1'b1, {1'b0, 1'b0, 8'h00});
    cmpn("stores after dirty hw store", s0 + 1, i_nv_sram_model.stores);
    send(CMD_HWSTORE, 13'h0000, 8'h00, 1'b1, {1'b0, 1'b0, 8'h00});
    cmpn("stores after clean hw store", s0 + 1, i_nv_sram_model.stores);
    wr(13'h0123, 8'hA5);
    send(CMD_RECALL, 13'h0000, 8'h00, 1'b1, {1'b0, 1'b0, 8'h00});
    cmpn("recalls", 1, i_nv_sram_model.recalls);
    mem[13'h0123] = 8'h5A;
    rd(13'h0123);
    wr(13'h0123, 8'h3C);
    send(CMD_SWSTORE, 13'h0000, 8'h00, 1'b0, {1'b0, 1'b0, 8'h00});
    cmpn("stores after sw store", s0 + 2, i_nv_sram_model.stores);
    wr(13'h0123, 8'hC3);
    send(CMD_RECALL, 13'h0000, 8'h00, 1'b0, {1'b0, 1'b0, 8'h00});
    cmpn("recalls", 2, i_nv_sram_model.recalls);
    mem[13'h0123] = 8'h3C;
    rd(13'h0123);
    for (i = 5; i < 8; i++) send(3'(i), 13'h0000, 8'h00, 1'b1, {1'b0, 1'b1, 8'h00});
    rd(a);
    cmpn("pin faults", 0, i_nv_sram_model.faults);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
